// ---- hdl/fsp_regs.svh ----
// Purpose: Register selects, field positions, reset values and timing for the
//          flash self-program control block
// Assumes: Core clock of 50 MHz
// Notes:   Definitions only
`ifndef FSP_REGS_SVH
`define FSP_REGS_SVH

// ----------------------------------------------------------------------
// Register selects on the core's special function port
// ----------------------------------------------------------------------
`define FSP_SEL_CTRL    3'h0
`define FSP_SEL_UNLOCK  3'h1
`define FSP_SEL_LATCH   3'h2
`define FSP_SEL_PTR_U   3'h3
`define FSP_SEL_PTR_H   3'h4
`define FSP_SEL_PTR_L   3'h5

// ----------------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------------
`define FSP_BIT_PGD     7
`define FSP_BIT_CFG_SEL 6
`define FSP_BIT_FREE    4
`define FSP_BIT_ERR     3
`define FSP_BIT_ALLOW   2
`define FSP_BIT_WR      1
`define FSP_BIT_RD      0

// ----------------------------------------------------------------------
// Unlock keys, reset values and timing
// ----------------------------------------------------------------------
`define FSP_KEY_FIRST   8'h55
`define FSP_KEY_SECOND  8'hAA
`define FSP_RST_BYTE    8'h00
`define FSP_RST_PTR     22'h000000
`define FSP_HOLD_BYTES  8
`define FSP_PROG_TIME_US 2000
`define FSP_CLK_MHZ     50

`endif

// ---- hdl/fsp_pkg.sv ----
// Purpose: Types shared by the flash self-program control block
// Assumes: Constants come from fsp_regs.svh
// Notes:   Carriers are packed structs
package fsp_pkg;

	// ------------------------------------------------------------------
	// Table pointer update modes
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		FSP_TBL_KEEP,
		FSP_TBL_POSTINC,
		FSP_TBL_POSTDEC,
		FSP_TBL_PREINC
	} fsp_tbl_mode_t;

	// ------------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [2:0] sel;
		logic [7:0] data;
	} fsp_reg_req_t;

	typedef struct packed {
		logic          go;
		logic          write;
		fsp_tbl_mode_t mode;
	} fsp_tbl_req_t;

	typedef struct packed {
		logic prog;
		logic erase;
		logic ee_write;
		logic cfg_write;
		logic ee_read;
	} fsp_nvm_cmd_t;

	typedef struct packed {
		logic pgd;
		logic cfg_sel;
		logic free;
		logic err;
		logic allow;
		logic wr;
		logic rd;
	} fsp_ctrl_t;

	typedef enum logic [1:0] {
		FSP_UNL_IDLE,
		FSP_UNL_STEP,
		FSP_UNL_ARMED
	} fsp_unlock_t;

endpackage : fsp_pkg

// ---- hdl/fsp_ctrl.sv ----
// Purpose: Table read/write, holding registers, control and unlock logic for
//          program flash self-programming and data EEPROM starts
// Assumes: Flash array returns flash_rdata_i combinationally for flash_addr_o
// Notes:   por_n_i alone clears the error flag and the space selects
`timescale 1ns/1ns
`include "fsp_regs.svh"

// What this block does
// - Reads one byte per operation, programs eight-byte blocks, erases 64-byte rows.
// - No bulk erase is reachable; only the row erase exists.
// - Fetch stalls during program or erase until the internal timer ends it.
// - Any byte value is accepted for programming; invalid opcodes execute as no-op.
// - Sixteen-bit flash and eight-bit RAM exchange bytes through the table latch.
// - Table writes fill holding registers; committing to flash is a separate start.
// - Table operations use any byte address, no word alignment needed.
// - The unlock register stores nothing and always reads zero.
// - Control bit 7 chooses flash (1) or data EEPROM (0).
// - Control bit 6 set targets configuration registers regardless of bit 7.
// - Row-erase enable with bit 7 set and bit 6 clear makes the next trigger erase; it clears when erase completes.
// - Write enable clears at power-up; write cycles need it set.
// - Error flag shows premature end; space selects survive that error.
// - Error flag sets with the write trigger, clears on normal completion.
// - Write trigger is set-only by software, cleared by hardware at completion.
// - Completion sets the done interrupt flag; software clears it.
// - Read trigger starts a one-cycle EEPROM read, refused when bit 7 or 6 set.
// - Control bit 5 always reads zero.
// - The table latch is an eight-bit register holding the byte in transit.
// - The pointer is 22 bits from three bytes; top bit reaches configuration space.
// - Table ops keep, post-increment, post-decrement or pre-increment the low 21 bits.
// - Table read loads the addressed byte; pointer bit 0 picks the word half.
module fsp_ctrl #(
	parameter int unsigned PROG_CYCLES = `FSP_PROG_TIME_US * `FSP_CLK_MHZ
) (
	input  wire logic                 clock_i,       // Core clock, 50 MHz
	input  wire logic                 nrst_i,        // Device reset, active low
	input  wire logic                 por_n_i,       // Power-on reset, active low
	input  wire fsp_pkg::fsp_reg_req_t reg_i,        // Register access from core
	input  wire fsp_pkg::fsp_tbl_req_t tbl_i,        // Table operation from core
	input  wire logic                 irq_clear_i,   // Software clears done flag
	input  wire logic [15:0]          flash_rdata_i, // Word at flash_addr_o
	output logic [7:0]                reg_rdata_o,   // Register read data
	output logic [21:0]               flash_addr_o,  // Byte, block or row address
	output logic [63:0]               flash_wdata_o, // Holding registers
	output fsp_pkg::fsp_nvm_cmd_t     cmd_o,         // Array commands
	output logic                      fetch_stall_o, // Instruction fetch halted
	output logic                      tbl_busy_o,    // Table read in flight
	output logic                      done_irq_o     // Completion interrupt flag
);
	import fsp_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_TRD, ST_LONG} fsp_state_t;

	// ------------------------------------------------------------------
	// Pointer arithmetic on the low 21 bits only
	// ------------------------------------------------------------------
	function automatic logic [21:0] fsp_step(input logic [21:0] p, input logic up);
		logic [20:0] low;
		low = up ? p[20:0] + 21'h000001 : p[20:0] - 21'h000001;
		return {p[21], low};
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	fsp_state_t          state;
	fsp_ctrl_t           ctl;
	logic                program_space_select;
	logic                config_space_select;
	logic                row_erase_enable;
	logic                program_error_flag;
	logic                program_cycle_allow;
	logic                write_trigger;
	logic                read_trigger;
	fsp_unlock_t         unl;
	logic [21:0]         ptr;
	logic [7:0]          latch;
	logic [7:0]          hold [`FSP_HOLD_BYTES];
	logic [16:0]         timer;

	// Control register view gathered from the flops of both reset domains
	assign ctl = '{pgd: program_space_select, cfg_sel: config_space_select,
	               free: row_erase_enable, err: program_error_flag,
	               allow: program_cycle_allow, wr: write_trigger, rd: read_trigger};

	// ------------------------------------------------------------------
	// Decode of register writes and table requests
	// ------------------------------------------------------------------
	wire logic        wr_ctrl   = reg_i.wr && reg_i.sel == `FSP_SEL_CTRL;
	wire logic        wr_unl    = reg_i.wr && reg_i.sel == `FSP_SEL_UNLOCK;
	wire logic        wr_latch  = reg_i.wr && reg_i.sel == `FSP_SEL_LATCH;
	wire logic        tbl_go    = tbl_i.go && state == ST_IDLE;
	wire logic        idle      = state == ST_IDLE;
	wire logic        start_req = wr_ctrl && reg_i.data[`FSP_BIT_WR] && !ctl.wr && idle;
	wire logic        start_ok  = start_req && ctl.allow && unl == FSP_UNL_ARMED;
	wire logic        rd_req    = wr_ctrl && reg_i.data[`FSP_BIT_RD] && idle;
	wire logic        rd_ok     = rd_req && !reg_i.data[`FSP_BIT_PGD]
	                            && !reg_i.data[`FSP_BIT_CFG_SEL];
	wire logic        timer_end = state == ST_LONG && timer == 17'h00000;
	wire logic [21:0] use_ptr   = tbl_i.mode == FSP_TBL_PREINC ? fsp_step(ptr, 1'b1) : ptr;
	wire logic        erase_sel = ctl.free && ctl.pgd && !ctl.cfg_sel;

	// Pointer value after the table operation
	logic [21:0] next_ptr;
	always_comb begin
		case (tbl_i.mode)
			FSP_TBL_POSTINC: next_ptr = fsp_step(ptr, 1'b1);
			FSP_TBL_POSTDEC: next_ptr = fsp_step(ptr, 1'b0);
			FSP_TBL_PREINC:  next_ptr = use_ptr;
			default:         next_ptr = ptr;
		endcase
	end

	// ------------------------------------------------------------------
	// Sequencer: table reads and the self-timed long cycle
	// ------------------------------------------------------------------
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state <= ST_IDLE;
			timer <= 17'h00000;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start_ok) begin
						state <= ST_LONG;
						timer <= 17'(PROG_CYCLES - 1);
					end else if (tbl_go && !tbl_i.write) begin
						state <= ST_TRD;
					end
				end
				ST_TRD:  state <= ST_IDLE;
				ST_LONG: begin
					if (timer_end) begin
						state <= ST_IDLE;
					end else begin
						timer <= timer - 17'h00001;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Pointer, latch and holding registers; byte addresses need no alignment
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ptr   <= `FSP_RST_PTR;
			latch <= `FSP_RST_BYTE;
			for (int i = 0; i < `FSP_HOLD_BYTES; i++) begin
				hold[i] <= `FSP_RST_BYTE;
			end
		end else begin
			if (tbl_go) begin
				ptr <= next_ptr;
			end else if (reg_i.wr && reg_i.sel == `FSP_SEL_PTR_U) begin
				ptr[21:16] <= reg_i.data[5:0];
			end else if (reg_i.wr && reg_i.sel == `FSP_SEL_PTR_H) begin
				ptr[15:8] <= reg_i.data;
			end else if (reg_i.wr && reg_i.sel == `FSP_SEL_PTR_L) begin
				ptr[7:0] <= reg_i.data;
			end
			if (state == ST_TRD) begin
				latch <= flash_addr_o[0] ? flash_rdata_i[15:8]
				                         : flash_rdata_i[7:0];
			end else if (wr_latch) begin
				latch <= reg_i.data;
			end
			if (tbl_go && tbl_i.write) begin
				hold[use_ptr[2:0]] <= latch;
			end
		end
	end

	// Flash address and data; a row erase ignores the low six bits
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			flash_addr_o  <= `FSP_RST_PTR;
			flash_wdata_o <= 64'h0000000000000000;
		end else if (tbl_go && !tbl_i.write) begin
			flash_addr_o <= use_ptr;
		end else if (start_ok) begin
			flash_addr_o  <= erase_sel ? {ptr[21:6], 6'h00}
			                           : {ptr[21:3], 3'h0};
			flash_wdata_o <= {hold[7], hold[6], hold[5], hold[4],
			                  hold[3], hold[2], hold[1], hold[0]};
		end
	end

	// ------------------------------------------------------------------
	// Unlock sequence tracker; the register itself holds no data
	// ------------------------------------------------------------------
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			unl <= FSP_UNL_IDLE;
		end else if (wr_unl) begin
			if (reg_i.data == `FSP_KEY_FIRST) begin
				unl <= FSP_UNL_STEP;
			end else if (reg_i.data == `FSP_KEY_SECOND && unl == FSP_UNL_STEP) begin
				unl <= FSP_UNL_ARMED;
			end else begin
				unl <= FSP_UNL_IDLE;
			end
		end else if (reg_i.wr || tbl_i.go) begin
			unl <= FSP_UNL_IDLE;
		end
	end

	// ------------------------------------------------------------------
	// Control bits cleared by device reset
	// ------------------------------------------------------------------
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			row_erase_enable    <= 1'b0;
			program_cycle_allow <= 1'b0;
			write_trigger       <= 1'b0;
			read_trigger        <= 1'b0;
		end else begin
			if (timer_end) begin
				write_trigger <= 1'b0;
				if (cmd_o.erase) begin
					row_erase_enable <= 1'b0;
				end
			end else if (wr_ctrl && idle) begin
				row_erase_enable    <= reg_i.data[`FSP_BIT_FREE];
				program_cycle_allow <= reg_i.data[`FSP_BIT_ALLOW];
				write_trigger       <= write_trigger | start_ok;
			end
			read_trigger <= rd_ok;
		end
	end

	// Error flag and space selects survive device reset for tracing
	always_ff @(posedge clock_i or negedge por_n_i) begin
		if (!por_n_i) begin
			program_error_flag   <= 1'b0;
			program_space_select <= 1'b0;
			config_space_select  <= 1'b0;
		end else begin
			if (start_req) begin
				program_error_flag <= 1'b1;
			end else if (timer_end) begin
				program_error_flag <= 1'b0;
			end else if (wr_ctrl && idle) begin
				program_error_flag <= reg_i.data[`FSP_BIT_ERR];
			end
			if (wr_ctrl && idle) begin
				program_space_select <= reg_i.data[`FSP_BIT_PGD];
				config_space_select  <= reg_i.data[`FSP_BIT_CFG_SEL];
			end
		end
	end

	// ------------------------------------------------------------------
	// Commands, status outputs and read data
	// ------------------------------------------------------------------
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cmd_o         <= '0;
			fetch_stall_o <= 1'b0;
			tbl_busy_o    <= 1'b0;
			done_irq_o    <= 1'b0;
			reg_rdata_o   <= `FSP_RST_BYTE;
		end else begin
			if (start_ok) begin
				cmd_o.cfg_write <= ctl.cfg_sel;
				cmd_o.prog      <= !ctl.cfg_sel && ctl.pgd && !ctl.free;
				cmd_o.erase     <= erase_sel;
				cmd_o.ee_write  <= !ctl.cfg_sel && !ctl.pgd;
			end else if (timer_end) begin
				cmd_o.cfg_write <= 1'b0;
				cmd_o.prog      <= 1'b0;
				cmd_o.erase     <= 1'b0;
				cmd_o.ee_write  <= 1'b0;
			end
			cmd_o.ee_read <= rd_ok;
			fetch_stall_o <= start_ok || (state == ST_LONG && !timer_end);
			tbl_busy_o    <= tbl_go && !tbl_i.write;
			done_irq_o    <= timer_end || (done_irq_o && !irq_clear_i);
			case (reg_i.sel)
				`FSP_SEL_CTRL:  reg_rdata_o <= {ctl.pgd, ctl.cfg_sel, 1'b0, ctl.free,
				                                ctl.err, ctl.allow, ctl.wr, ctl.rd};
				`FSP_SEL_LATCH: reg_rdata_o <= latch;
				`FSP_SEL_PTR_U: reg_rdata_o <= {2'b00, ptr[21:16]};
				`FSP_SEL_PTR_H: reg_rdata_o <= ptr[15:8];
				`FSP_SEL_PTR_L: reg_rdata_o <= ptr[7:0];
				default:        reg_rdata_o <= `FSP_RST_BYTE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	chk_unlock_reads_zero: assert property (@(posedge clock_i) disable iff (!nrst_i)
		reg_i.rd && reg_i.sel == `FSP_SEL_UNLOCK |=> reg_rdata_o == 8'h00)
		else $error("unlock register read nonzero");

	chk_bit5_zero: assert property (@(posedge clock_i) disable iff (!nrst_i)
		reg_i.rd && reg_i.sel == `FSP_SEL_CTRL |=> !reg_rdata_o[5])
		else $error("control bit 5 read as one");

	chk_stall_span: assert property (@(posedge clock_i) disable iff (!nrst_i)
		start_ok |=> fetch_stall_o [*8])
		else $error("fetch not stalled after start");

	chk_locked_trigger: assert property (@(posedge clock_i) disable iff (!nrst_i)
		start_req && unl != FSP_UNL_ARMED |=> !fetch_stall_o && !ctl.wr)
		else $error("trigger accepted without unlock");

	chk_err_on_start: assert property (@(posedge clock_i) disable iff (!nrst_i)
		$rose(fetch_stall_o) |-> ctl.err && ctl.wr)
		else $error("error flag not set at cycle start");

	chk_done_clears: assert property (@(posedge clock_i) disable iff (!nrst_i)
		timer_end |=> !ctl.wr && !ctl.err && done_irq_o && !fetch_stall_o
		&& !(ctl.free && $past(cmd_o.erase)))
		else $error("completion did not clear trigger");

	chk_rd_refused: assert property (@(posedge clock_i) disable iff (!nrst_i)
		rd_req && (reg_i.data[`FSP_BIT_PGD] || reg_i.data[`FSP_BIT_CFG_SEL])
		|=> !cmd_o.ee_read && !ctl.rd)
		else $error("read trigger set with flash or config selected");

	chk_ptr_top_kept: assert property (@(posedge clock_i) disable iff (!nrst_i)
		tbl_go |=> ptr[21] == $past(ptr[21]))
		else $error("table op changed pointer top bit");

endmodule // fsp_ctrl

// ---- verification/fsp_flash_model.sv ----
// Purpose: Flash array model that answers word reads for the control block
// Assumes: Combinational read of the word that holds a byte address
// Notes:   Byte a holds a[8:1], inverted when a is odd, so each half differs
`timescale 1ns/1ns
module fsp_flash_model (
	input  wire logic [21:0] addr_i,  // Byte address from the block
	output logic      [15:0] rdata_o  // Sixteen-bit word holding that byte
);
	// ------------------------------------------------------------------
	// Word pattern: high byte sits at the odd address
	// ------------------------------------------------------------------
	assign rdata_o = {~addr_i[8:1], addr_i[8:1]};
endmodule // fsp_flash_model

// ---- verification/flash_self_program_control_tb_top.sv ----
// Purpose: Self-checking bench for the flash self-program control block
// Assumes: Programming timer shortened to CYC cycles
// Notes:   Inputs change by non-blocking assignment at rising edges
`timescale 1ns/1ns
`include "fsp_regs.svh"
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin \
	$display("CHECK FAILED %s expected %h seen %h", nm, ex, got); fail_count++; end end

module flash_self_program_control_tb_top;
	import fsp_pkg::*;
	localparam int unsigned CYC = 20;
	logic         clock_i = 1'b0;
	logic         nrst_i = 1'b0;
	logic         por_n_i = 1'b0;
	fsp_reg_req_t reg_i = '0;
	fsp_tbl_req_t tbl_i = '0;
	logic         irq_clear_i = 1'b0;
	logic [15:0]  flash_rdata_i;
	logic [7:0]   reg_rdata_o;
	logic [21:0]  flash_addr_o;
	logic [63:0]  flash_wdata_o;
	fsp_nvm_cmd_t cmd_o;
	logic         fetch_stall_o;
	logic         tbl_busy_o;
	logic         done_irq_o;
	int           fail_count = 0;
	int           samples_checked = 0;
	int           cycles = 0;
	logic [63:0]  exp_hold = '0;

	// ------------------------------------------------------------------
	// Design and flash array
	// ------------------------------------------------------------------
	fsp_ctrl #(.PROG_CYCLES(CYC)) DUT (.clock_i(clock_i), .nrst_i(nrst_i), .por_n_i(por_n_i),
		.reg_i(reg_i), .tbl_i(tbl_i), .irq_clear_i(irq_clear_i),
		.flash_rdata_i(flash_rdata_i), .reg_rdata_o(reg_rdata_o),
		.flash_addr_o(flash_addr_o), .flash_wdata_o(flash_wdata_o), .cmd_o(cmd_o),
		.fetch_stall_o(fetch_stall_o), .tbl_busy_o(tbl_busy_o), .done_irq_o(done_irq_o));
	fsp_flash_model u_flash (.addr_i(flash_addr_o), .rdata_o(flash_rdata_i));

	// Clock and hang guard
	always #10 clock_i = ~clock_i;
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fail_count++;
			end_of_test();
		end
	end

	// ------------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------------
	task automatic end_of_test();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic wreg(input logic [2:0] s, input logic [7:0] d);
		@(posedge clock_i);
		reg_i <= '{wr: 1'b1, rd: 1'b0, sel: s, data: d};
		@(posedge clock_i);
		reg_i.wr <= 1'b0;
	endtask

	// Read data follows the select one edge later
	task automatic ck(input string nm, input logic [2:0] s, input logic [7:0] e);
		@(posedge clock_i);
		reg_i.sel <= s;
		reg_i.rd <= 1'b1;
		@(posedge clock_i);
		reg_i.rd <= 1'b0;
		#1;
		`CHK(nm, e, reg_rdata_o)
	endtask

	task automatic tblop(input logic w, input fsp_tbl_mode_t m);
		@(posedge clock_i);
		tbl_i <= '{go: 1'b1, write: w, mode: m};
		@(posedge clock_i);
		tbl_i.go <= 1'b0;
		#1;
	endtask

	task automatic set_ptr(input logic [7:0] u, input logic [7:0] h, input logic [7:0] l);
		wreg(`FSP_SEL_PTR_U, u);
		wreg(`FSP_SEL_PTR_H, h);
		wreg(`FSP_SEL_PTR_L, l);
	endtask

	// Setup, unlock, trigger, then time the long cycle and clear the flag
	task automatic start(input logic [7:0] c, input fsp_nvm_cmd_t e, input logic st,
		input logic [21:0] a);
		int n;
		wreg(`FSP_SEL_CTRL, c);
		wreg(`FSP_SEL_UNLOCK, `FSP_KEY_FIRST);
		wreg(`FSP_SEL_UNLOCK, `FSP_KEY_SECOND);
		wreg(`FSP_SEL_CTRL, c | 8'h02);
		#1;
		`CHK("command", e, cmd_o)
		`CHK("fetch stall", st, fetch_stall_o)
		if (e.prog || e.erase) begin
			`CHK("flash address", a, flash_addr_o)
		end
		if (e.prog) begin
			`CHK("write data", exp_hold, flash_wdata_o)
		end
		n = 1;
		while (cmd_o !== '0 && n < 200) begin
			@(posedge clock_i);
			#1;
			if (cmd_o !== '0) n++;
		end
		`CHK("cycle length", CYC, n)
		`CHK("done flag", 1'b1, done_irq_o)
		@(posedge clock_i);
		irq_clear_i <= 1'b1;
		@(posedge clock_i);
		irq_clear_i <= 1'b0;
		#1;
		`CHK("done flag", 1'b0, done_irq_o)
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset_values();
		ck("control", `FSP_SEL_CTRL, 8'h00);
		wreg(`FSP_SEL_UNLOCK, `FSP_KEY_FIRST);
		ck("unlock", `FSP_SEL_UNLOCK, 8'h00);
		wreg(`FSP_SEL_CTRL, 8'h20);
		ck("control", `FSP_SEL_CTRL, 8'h00);
	endtask

	task automatic t_table_read();
		set_ptr(8'h00, 8'h01, 8'h23);
		tblop(1'b0, FSP_TBL_POSTINC);
		`CHK("read address", 22'h000123, flash_addr_o)
		`CHK("read busy", 1'b1, tbl_busy_o)
		ck("latch", `FSP_SEL_LATCH, 8'h6E);
		tblop(1'b0, FSP_TBL_KEEP);
		`CHK("read address", 22'h000124, flash_addr_o)
		ck("latch", `FSP_SEL_LATCH, 8'h92);
		tblop(1'b0, FSP_TBL_POSTDEC);
		ck("pointer low", `FSP_SEL_PTR_L, 8'h23);
		ck("latch", `FSP_SEL_LATCH, 8'h92);
		set_ptr(8'hFF, 8'hFF, 8'hFF);
		ck("pointer upper", `FSP_SEL_PTR_U, 8'h3F);
		tblop(1'b0, FSP_TBL_PREINC);
		`CHK("read address", 22'h200000, flash_addr_o)
		ck("pointer upper", `FSP_SEL_PTR_U, 8'h20);
	endtask

	task automatic t_program();
		set_ptr(8'h00, 8'h01, 8'h3F);
		for (int i = 0; i < `FSP_HOLD_BYTES; i++) begin
			wreg(`FSP_SEL_LATCH, 8'h30 + 8'(i));
			tblop(1'b1, FSP_TBL_PREINC);
			exp_hold[8*i +: 8] = 8'h30 + 8'(i);
		end
		`CHK("command", 5'h00, cmd_o)
		start(8'h84, 5'h10, 1'b1, 22'h000140);
		ck("control", `FSP_SEL_CTRL, 8'h84);
	endtask

	task automatic t_erase();
		wreg(`FSP_SEL_PTR_L, 8'hAB);
		start(8'h94, 5'h08, 1'b1, 22'h000180);
		ck("control", `FSP_SEL_CTRL, 8'h84);
	endtask

	task automatic t_refused();
		wreg(`FSP_SEL_CTRL, 8'h86);
		#1;
		`CHK("command", 5'h00, cmd_o)
		ck("control", `FSP_SEL_CTRL, 8'h8C);
		wreg(`FSP_SEL_CTRL, 8'h80);
		wreg(`FSP_SEL_UNLOCK, `FSP_KEY_FIRST);
		wreg(`FSP_SEL_UNLOCK, `FSP_KEY_SECOND);
		wreg(`FSP_SEL_CTRL, 8'h82);
		#1;
		`CHK("command", 5'h00, cmd_o)
		ck("control", `FSP_SEL_CTRL, 8'h88);
	endtask

	task automatic t_eeprom();
		wreg(`FSP_SEL_CTRL, 8'h00);
		wreg(`FSP_SEL_CTRL, 8'h01);
		#1;
		`CHK("command", 5'h01, cmd_o)
		@(posedge clock_i);
		#1;
		`CHK("command", 5'h00, cmd_o)
		wreg(`FSP_SEL_CTRL, 8'h81);
		#1;
		`CHK("command", 5'h00, cmd_o)
		wreg(`FSP_SEL_CTRL, 8'h41);
		#1;
		`CHK("command", 5'h00, cmd_o)
		start(8'h04, 5'h04, 1'b1, 22'h000000);
		start(8'hC4, 5'h02, 1'b1, 22'h000000);
	endtask

	task automatic t_reset_mid();
		wreg(`FSP_SEL_CTRL, 8'h84);
		wreg(`FSP_SEL_UNLOCK, `FSP_KEY_FIRST);
		wreg(`FSP_SEL_UNLOCK, `FSP_KEY_SECOND);
		wreg(`FSP_SEL_CTRL, 8'h86);
		repeat (9) @(posedge clock_i);
		nrst_i <= 1'b0;
		@(posedge clock_i);
		nrst_i <= 1'b1;
		#1;
		`CHK("fetch stall", 1'b0, fetch_stall_o)
		ck("control", `FSP_SEL_CTRL, 8'h88);
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clock_i);
		nrst_i <= 1'b1;
		por_n_i <= 1'b1;
		t_reset_values();
		t_table_read();
		t_program();
		t_erase();
		t_refused();
		t_eeprom();
		t_reset_mid();
		end_of_test();
	end
endmodule // flash_self_program_control_tb_top
